// [hdl/fps_pkg.sv]
// Package for the flyback protection supervisor: timing constants and carrier types
package fps_pkg;

    // Clock rate, in the units the derived counts need
    localparam int CLK_KHZ = 50_000;
    localparam int CLK_MHZ = 50;

    // Printed times, each in its own unit
    localparam int OPP_START_MS  = 40;    // Overpower timeout in start-up
    localparam int OPP_NORM_MS   = 200;   // Overpower timeout in normal run
    localparam int RESTART_MS    = 1000;  // Safe-restart wait
    localparam int BROWNOUT_MS   = 30;    // Brownout qualification
    localparam int PROT_QUAL_MS  = 2;     // External protect qualification, low end of 2..4 ms
    localparam int LEB_NS        = 325;   // Leading-edge blanking
    localparam int MAX_ON_US     = 55;    // Longest driver on-pulse
    localparam int OVP_CYCLES    = 4;     // Overvoltage qualification, switching cycles

    // Cycle counts: least times round up, the longest on-time rounds down
    localparam logic [31:0] OPP_START_CYC = 32'(OPP_START_MS * CLK_KHZ);
    localparam logic [31:0] OPP_NORM_CYC  = 32'(OPP_NORM_MS * CLK_KHZ);
    localparam logic [31:0] RESTART_CYC   = 32'(RESTART_MS * CLK_KHZ);
    localparam logic [31:0] BROWNOUT_CYC  = 32'(BROWNOUT_MS * CLK_KHZ);
    localparam logic [31:0] PROT_QUAL_CYC = 32'(PROT_QUAL_MS * CLK_KHZ);
    localparam logic [4:0]  LEB_CYC       = 5'((LEB_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] MAX_ON_CYC    = 12'(MAX_ON_US * CLK_MHZ);
    localparam logic [2:0]  OVP_CYC       = 3'(OVP_CYCLES);

    // Number of qualified input flags
    localparam int FLAG_W = 11;

    // Comparator and fault flags, all active high, all asynchronous to clk_i
    typedef struct packed {
        logic pwm_req;          // Modulator asks for the switch to be on
        logic startup_done;     // Soft start has reached full level
        logic opp_over;         // Current sense above the overpower level
        logic peak_cur;         // Peak current comparator
        logic undervoltage_lockout;
        logic low_supply_rail_ovp;         // Low supply rail above its overvoltage level
        logic aux_ovp;          // Auxiliary winding overvoltage
        logic otp_int;          // Internal over-temperature, hysteresis in the sensor
        logic protect_low;      // External protect input low, hysteresis in comparator
        logic brownout;         // Mains below the brown-in level
        logic aux_open;         // Auxiliary sense input open
    } fps_flags_t;

    // Supervisor states
    typedef enum logic [2:0] {
        ST_WAIT_UNDERVOLTAGE_LOCKOUT,
        ST_RUN,
        ST_RESTART,
        ST_WAIT_AUX,
        ST_WAIT_BROWN
    } fps_state_t;

endpackage

// [hdl/fps_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous flags
`timescale 1ns/1ps
module fps_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    import fps_pkg::*;

    logic [W-1:0] meta_r;  // First stage, read only by the second stage

    // One pair of flops per bit
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                meta_r[g] <= 1'b0;
                sync_o[g] <= 1'b0;
            end else begin
                meta_r[g] <= async_i[g];
                sync_o[g] <= meta_r[g];
            end
        end
    end

endmodule // fps_sync

// [hdl/fps_supervisor.sv]
// Flyback protection supervisor: driver gating, overpower timer, safe restart
`timescale 1ns/1ps
module fps_supervisor
    import fps_pkg::*;
#(
    parameter logic [31:0] OPP_START_LIM = fps_pkg::OPP_START_CYC,
    parameter logic [31:0] OPP_NORM_LIM  = fps_pkg::OPP_NORM_CYC,
    parameter logic [31:0] RESTART_LIM   = fps_pkg::RESTART_CYC,
    parameter logic [31:0] BROWNOUT_LIM  = fps_pkg::BROWNOUT_CYC,
    parameter logic [31:0] PROT_QUAL_LIM = fps_pkg::PROT_QUAL_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    input  wire fps_pkg::fps_flags_t flags_i,
    output logic                    drv_on_o,
    output logic                    hv_reg_o,
    output logic                    startup_o,
    output fps_pkg::fps_state_t     state_o
);
    import fps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    fps_flags_t  f;              // Synchronised flags
    fps_state_t  state_r;        // Supervisor state
    logic        pwm_q_r;        // Previous request, for cycle edges
    logic        cyc_start;      // First clock of a switching cycle
    logic        drv_r;          // Driver gate
    logic        hv_r;           // HV source regulating the rail
    logic        startup_r;      // Start-up phase, selects the short timeout
    logic [11:0] on_cnt_r;       // Driver on-time
    logic [4:0]  leb_cnt_r;      // Blanking counter
    logic        peak_blk_r;     // Pulse ended by peak current
    logic        opp_run_r;      // Overpower timer running
    logic        opp_seen_r;     // Overpower seen in this cycle
    logic [31:0] opp_cnt_r;      // Overpower timer
    logic [2:0]  ovp_cnt_r [2];  // Per-cycle overvoltage counts, 0 rail, 1 aux
    logic [31:0] bo_cnt_r;       // Brownout qualification
    logic [31:0] prot_cnt_r;     // Protect input qualification
    logic [31:0] rst_cnt_r;      // Restart wait
    logic        opp_expire;     // Overpower timeout reached
    logic        maxon_trip;     // On-time limit reached
    logic        peak_trip;      // Peak comparator seen after blanking
    logic        bo_trip;        // Brownout qualified
    logic        prot_trip;      // Protect input qualified
    logic        restart_trip;   // Any cause that goes through safe restart
    logic        stop_now;       // Any cause that leaves the run state
    logic        hold_restart;   // Restart withheld by a still-present fault

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    fps_sync #(.W(FLAG_W)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (flags_i),
        .sync_o    (f)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Trip decode
    always_comb begin
        cyc_start    = f.pwm_req & ~pwm_q_r;
        opp_expire   = opp_run_r &&
                       (opp_cnt_r >= (startup_r ? OPP_START_LIM : OPP_NORM_LIM) - 32'h1);
        maxon_trip   = drv_r && (on_cnt_r >= MAX_ON_CYC - 12'h1);
        peak_trip    = drv_r && (leb_cnt_r >= LEB_CYC) && f.peak_cur;
        bo_trip      = f.brownout && (bo_cnt_r >= BROWNOUT_LIM - 32'h1);
        prot_trip    = f.protect_low && (prot_cnt_r >= PROT_QUAL_LIM - 32'h1);
        // Every recoverable protection but brownout, open aux and plain undervoltage is routed through restart
        restart_trip = opp_expire | maxon_trip | f.otp_int | prot_trip
                     | (ovp_cnt_r[0] >= OVP_CYC)
                     | (ovp_cnt_r[1] >= OVP_CYC)
                     | (f.undervoltage_lockout & (opp_run_r | f.opp_over));
        stop_now     = restart_trip | bo_trip | f.aux_open | f.undervoltage_lockout;
        hold_restart = f.otp_int | f.protect_low;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle edge detector, reads the synchronised request only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwm_q_r <= 1'b0;
        end else begin
            pwm_q_r <= f.pwm_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supervisor state machine; power-up starts in the undervoltage wait
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r   <= ST_WAIT_UNDERVOLTAGE_LOCKOUT;
            startup_r <= 1'b1;
            rst_cnt_r <= 32'h0;
        end else begin
            // Start-up ends once soft start has finished
            if (f.startup_done) begin
                startup_r <= 1'b0;
            end
            unique case (state_r)
                ST_RUN: begin
                    // Open aux wins, then restart causes, undervoltage, brownout
                    rst_cnt_r <= 32'h0;
                    if (f.aux_open) begin
                        state_r <= ST_WAIT_AUX;
                    end else if (restart_trip) begin
                        state_r <= ST_RESTART;
                    end else if (f.undervoltage_lockout) begin
                        state_r <= ST_WAIT_UNDERVOLTAGE_LOCKOUT;
                    end else if (bo_trip) begin
                        state_r <= ST_WAIT_BROWN;
                    end
                end
                ST_RESTART: begin
                    // Fixed wait, then resume as a fresh start-up once otp_int and protect_low are both clear
                    if (rst_cnt_r < RESTART_LIM - 32'h1) begin
                        rst_cnt_r <= rst_cnt_r + 32'h1;
                    end else if (!hold_restart) begin
                        state_r   <= ST_RUN;
                        startup_r <= 1'b1;
                    end
                end
                ST_WAIT_AUX: begin
                    if (!f.aux_open) begin
                        state_r   <= ST_RUN;
                        startup_r <= 1'b1;
                    end
                end
                ST_WAIT_BROWN: begin
                    if (!f.brownout) begin
                        state_r   <= ST_RUN;
                        startup_r <= 1'b1;
                    end
                end
                ST_WAIT_UNDERVOLTAGE_LOCKOUT: begin
                    if (!f.undervoltage_lockout) begin
                        state_r   <= ST_RUN;
                        startup_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rail regulation from the HV source: everywhere but run and open aux
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hv_r <= 1'b1;
        end else begin
            hv_r <= (state_r != ST_RUN) && (state_r != ST_WAIT_AUX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Driver gate, on-time and blanking
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drv_r      <= 1'b0;
            on_cnt_r   <= 12'h0;
            leb_cnt_r  <= 5'h0;
            peak_blk_r <= 1'b0;
        end else begin
            // Peak current ends the pulse; the block lasts until the request drops
            if (!f.pwm_req) begin
                peak_blk_r <= 1'b0;
            end else if (peak_trip) begin
                peak_blk_r <= 1'b1;
            end
            drv_r <= (state_r == ST_RUN) && !stop_now && f.pwm_req
                     && !peak_blk_r && !peak_trip;
            if (drv_r) begin
                on_cnt_r <= on_cnt_r + 12'h1;
                // Counter saturates so blanking is counted once per pulse
                if (leb_cnt_r < LEB_CYC) begin
                    leb_cnt_r <= leb_cnt_r + 5'h1;
                end
            end else begin
                on_cnt_r  <= 12'h0;
                leb_cnt_r <= 5'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overpower timer; flag is taken as the switch-off level comparison
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            opp_run_r  <= 1'b0;
            opp_seen_r <= 1'b0;
            opp_cnt_r  <= 32'h0;
        end else if (state_r != ST_RUN) begin
            opp_run_r  <= 1'b0;
            opp_seen_r <= 1'b0;
            opp_cnt_r  <= 32'h0;
        end else begin
            if (cyc_start && !opp_seen_r && !f.opp_over) begin
                opp_run_r <= 1'b0;
                opp_cnt_r <= 32'h0;
            end else if (opp_run_r) begin
                opp_cnt_r <= opp_cnt_r + 32'h1;
            end
            if (f.opp_over) begin
                opp_run_r <= 1'b1;
            end
            // Seen flag is per cycle; a flag in the edge cycle counts for the new one
            opp_seen_r <= cyc_start ? f.opp_over : (opp_seen_r | f.opp_over);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overvoltage qualification over consecutive switching cycles
    for (genvar g = 0; g < 2; g++) begin : g_ovp
        logic ovp_in;
        assign ovp_in = (g == 0) ? f.low_supply_rail_ovp : f.aux_ovp;
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                ovp_cnt_r[g] <= 3'h0;
            end else if (state_r != ST_RUN || !ovp_in) begin
                ovp_cnt_r[g] <= 3'h0;
            end else if (cyc_start && ovp_cnt_r[g] < OVP_CYC) begin
                ovp_cnt_r[g] <= ovp_cnt_r[g] + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay qualifiers for brownout and the external protect input
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bo_cnt_r   <= 32'h0;
            prot_cnt_r <= 32'h0;
        end else begin
            bo_cnt_r   <= (f.brownout && state_r == ST_RUN) ? bo_cnt_r + 32'h1 : 32'h0;
            prot_cnt_r <= (f.protect_low && state_r == ST_RUN) ? prot_cnt_r + 32'h1 : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign drv_on_o  = drv_r;
    assign hv_reg_o  = hv_r;
    assign startup_o = startup_r;
    assign state_o   = state_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_drv_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r != ST_RUN) |=> !drv_r) else $error("driver on outside run");
    chk_leb_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (drv_r && leb_cnt_r < LEB_CYC - 5'h1 && f.pwm_req && state_r == ST_RUN
         && !stop_now) |=> drv_r) else $error("pulse cut inside blanking");
    chk_max_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        drv_r |-> on_cnt_r < MAX_ON_CYC) else $error("on-time above limit");
    chk_opp_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && cyc_start && !opp_seen_r && !f.opp_over)
        |=> (opp_cnt_r == 32'h0 && !opp_run_r)) else $error("timer not cleared");
    chk_opp_expire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && opp_expire && !f.aux_open) |=> state_r == ST_RESTART)
        else $error("timeout without restart");
    chk_undervoltage_lockout_opp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && f.undervoltage_lockout && opp_run_r && !f.aux_open)
        |=> state_r == ST_RESTART) else $error("undervoltage_lockout with overpower not restarted");
    chk_restart_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RESTART && rst_cnt_r < RESTART_LIM - 32'h1)
        |=> state_r == ST_RESTART) else $error("restart left early");
    chk_restart_rail: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RESTART)[*2] |-> (hv_r && !drv_r)) else $error("restart rail off");
    chk_aux_open: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && f.aux_open) |=> (state_r == ST_WAIT_AUX ##1 !hv_r))
        else $error("aux open not handled");
    chk_ovp_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && ovp_cnt_r[0] == OVP_CYC && !f.aux_open)
        |=> state_r == ST_RESTART) else $error("rail overvoltage not restarted");

endmodule // fps_supervisor

// [sim/fps_plant.sv]
// Partner model: modulator request source and peak current comparator
`timescale 1ns/1ps
module fps_plant (
    input  wire logic        clk_i,
    input  wire logic [12:0] per_i,   // Switching period in clocks, 0 stops
    input  wire logic [12:0] pk_i,    // On-clocks until peak trips, 0 never
    input  wire logic        drv_i,
    output logic             pwm_o,
    output logic             peak_o
);
    logic [12:0] cnt_r = 13'h0000;     // Position in the switching period
    logic [12:0] on_r  = 13'h0000;     // Clocks the driver has been on

    ////////////////////////////////////////////////////////////////////////
    // Request is high for the first half of each period
    always_ff @(posedge clk_i) begin
        cnt_r <= (cnt_r >= per_i - 13'h0001) ? 13'h0000 : cnt_r + 13'h0001;
        pwm_o <= (per_i != 13'h0000) && (cnt_r < (per_i >> 1));
    end

    // Ramp only while the switch conducts; falls back to 0 when it is off
    always_ff @(posedge clk_i) begin
        on_r   <= drv_i ? on_r + 13'h0001 : 13'h0000;
        peak_o <= drv_i && (pk_i != 13'h0000) && (on_r >= pk_i);
    end
endmodule // fps_plant

// [sim/testbench.sv]
// Self-checking bench for the flyback protection supervisor
`timescale 1ns/1ps
module testbench;
    import fps_pkg::*;
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    fps_flags_t  f;                    // Fault flags from the bench
    fps_flags_t  fl;                   // Flags as the block sees them
    logic        drv_on_o;
    logic        hv_reg_o;
    logic        startup_o;
    fps_state_t  state_o;
    logic        pwm;
    logic        pk;
    logic [12:0] per = 13'h0080;
    logic [12:0] pkc = 13'h0019;
    int          bad_count = 0;
    int          checked   = 0;

    ////////////////////////////////////////////////////////////////////////
    // Small limits keep the run short; expectations derive from these
    fps_supervisor #(.OPP_START_LIM(32'h32), .OPP_NORM_LIM(32'hC8), .RESTART_LIM(32'h64),
        .BROWNOUT_LIM(32'h1E), .PROT_QUAL_LIM(32'hA)) i_fps_supervisor (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .flags_i(fl), .drv_on_o(drv_on_o), .hv_reg_o(hv_reg_o),
        .startup_o(startup_o), .state_o(state_o));
    fps_plant i_fps_plant (.clk_i(clk_i), .per_i(per), .pk_i(pkc), .drv_i(drv_on_o),
        .pwm_o(pwm), .peak_o(pk));

    // Partner drives the switching request and the peak comparator
    always_comb begin
        fl          = f;
        fl.pwm_req  = pwm;
        fl.peak_cur = pk;
    end

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_b(input logic a, input logic e);
        checked++;
        if (a !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic cmp_s(input fps_state_t a, input fps_state_t e);
        checked++;
        if (a !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, a, e);
        end
    endtask

    // Bounded wait for a state; arrival must fall inside lo..hi clocks
    task automatic wait_st(input fps_state_t e, input int lo, input int hi);
        int n;
        n = 0;
        while (state_o !== e && n <= hi) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        checked++;
        if (n < lo || n > hi) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, n, lo);
            if (n > hi) tally_and_finish();
        end
    endtask

    // Waits for a fresh driver pulse, bounded by one long period
    task automatic wait_rise;
        int n;
        n = 0;
        while (drv_on_o !== 1'b0 && n < 9000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (drv_on_o !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 9000) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, n, 9000);
            tally_and_finish();
        end
    endtask

    // Clears every fault, keeps the soft-start flag, waits for normal run
    task automatic clean;
        fps_flags_t n;
        n              = '0;
        n.startup_done = f.startup_done;
        @(posedge clk_i);
        f <= n;
        wait_st(ST_RUN, 0, 130);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_leb;
        pkc <= 13'h0005;                  // Spike inside the blanking window
        wait_rise();
        repeat (12) @(posedge clk_i);
        #1 cmp_b(drv_on_o, 1'b1);
        pkc <= 13'h0019;                  // Real trip after blanking
        wait_rise();
        repeat (35) @(posedge clk_i);
        #1 cmp_b(drv_on_o, 1'b0);
    endtask

    task automatic t_opp(input logic norm, input int lo, input int hi);
        @(posedge clk_i);
        f.startup_done <= norm;
        repeat (5) @(posedge clk_i);
        #1 cmp_b(startup_o, ~norm);
        @(posedge clk_i);
        f.opp_over <= 1'b1;
        wait_st(ST_RESTART, lo, hi);
        cmp_b(drv_on_o, 1'b0);
        // Rail regulation follows the state one clock later
        @(posedge clk_i);
        f.opp_over <= 1'b0;
        f.startup_done <= 1'b0;
        #1 cmp_b(hv_reg_o, 1'b1);
        wait_st(ST_RUN, 95, 110);
        cmp_b(startup_o, 1'b1);
    endtask

    task automatic t_opp_clear;
        per <= 13'h0028;
        @(posedge clk_i);
        f.startup_done <= 1'b1;
        repeat (4) begin
            @(posedge clk_i) f.opp_over <= 1'b1;
            repeat (20) @(posedge clk_i);
            f.opp_over <= 1'b0;
            repeat (80) @(posedge clk_i);
            #1 cmp_s(state_o, ST_RUN);
        end
    endtask

    task automatic t_hold(input int which, input int lo, input int hi);
        @(posedge clk_i);
        case (which)
            0: f.otp_int <= 1'b1;
            1: f.protect_low <= 1'b1;
            2: f.low_supply_rail_ovp <= 1'b1;
            default: f.aux_ovp <= 1'b1;
        endcase
        wait_st(ST_RESTART, lo, hi);
        if (which < 2) begin
            repeat (150) @(posedge clk_i);
            #1 cmp_s(state_o, ST_RESTART);
        end
        clean();
    endtask

    // Wait states: 0 open aux, 1 brownout, 2 undervoltage alone
    task automatic t_wait(input int which, input fps_state_t st, input logic hv);
        @(posedge clk_i);
        if (which == 0) f.aux_open <= 1'b1;
        else if (which == 1) f.brownout <= 1'b1;
        else f.undervoltage_lockout <= 1'b1;
        wait_st(st, (which == 1) ? 25 : 0, (which == 1) ? 40 : 6);
        cmp_b(drv_on_o, 1'b0);
        // Rail regulation follows the state one clock later
        @(posedge clk_i);
        #1 cmp_b(hv_reg_o, hv);
        clean();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        f                      = '0;
        f.undervoltage_lockout = 1'b1;
        repeat (16) @(posedge clk_i);
        cmp_b(drv_on_o, 1'b0);
        cmp_b(hv_reg_o, 1'b1);
        cmp_b(startup_o, 1'b1);
        cmp_s(state_o, ST_WAIT_UNDERVOLTAGE_LOCKOUT);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1 cmp_s(state_o, ST_WAIT_UNDERVOLTAGE_LOCKOUT);
        clean();
        t_leb();
        t_opp(1'b0, 45, 60);
        t_opp(1'b1, 190, 215);
        t_opp_clear();
        @(posedge clk_i);
        f.opp_over <= 1'b1;
        f.undervoltage_lockout <= 1'b1;
        wait_st(ST_RESTART, 0, 8);
        clean();
        t_hold(0, 0, 6);
        t_hold(1, 8, 16);
        t_hold(2, 115, 170);
        t_hold(3, 115, 170);
        t_wait(0, ST_WAIT_AUX, 1'b0);
        t_wait(1, ST_WAIT_BROWN, 1'b1);
        t_wait(2, ST_WAIT_UNDERVOLTAGE_LOCKOUT, 1'b1);
        pkc <= 13'h0000;
        per <= 13'h1FFF;
        wait_rise();
        wait_st(ST_RESTART, 2740, 2760);
        tally_and_finish();
    end
endmodule // testbench
